// ==== dv/dual_gpio_port_assertions.sv ====
/* checker for the dual port block: bus answers and pin relations.
   sees only top-level ports; bound by the statement at the foot. */
`timescale 1ns/1ps
module dual_gpio_port_assertions
   import gpio_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst_n, // reset
   input wire logic s_axi_awvalid, // aw valid
   input wire logic s_axi_awready, // aw ready
   input wire logic s_axi_wvalid, // w valid
   input wire logic s_axi_wready, // w ready
   input wire logic s_axi_bvalid, // b valid
   input wire logic s_axi_arvalid, // ar valid
   input wire logic s_axi_arready, // ar ready
   input wire logic s_axi_rvalid, // r valid
   input wire logic s_axi_rready, // r ready
   input wire logic [31:0] s_axi_rdata, // read data
   input wire logic [PORT_W-1:0] a_pin_out, // a drive
   input wire logic [PORT_W-1:0] a_pin_oe, // a enable
   input wire logic [PORT_W-1:0] a_pull_up_en, // a pulls
   input wire logic [PORT_W-1:0] b_pin_out, // b drive
   input wire logic [PORT_W-1:0] b_pin_oe, // b enable
   input wire logic [PORT_W-1:0] b_pull_up_en, // b pulls
   input wire logic [PORT_W-1:0] b_pin_in, // b levels
   input wire alt_func_t alt_func // b synced levels
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [1:0] up_cnt; // edges since reset, so history from reset is skipped
   // saturating count of edges out of reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) up_cnt <= 2'h0;
      else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
   end
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_reset_tristate;
      $rose(rst_n) |-> (a_pin_oe | b_pin_oe | a_pull_up_en | b_pull_up_en) == 8'h00;
   endproperty
   a_reset_tristate: assert property (p_reset_tristate) else $error("pins active out of reset");
   property p_no_pull_on_output;
      ((a_pull_up_en & a_pin_oe) | (b_pull_up_en & b_pin_oe)) == 8'h00;
   endproperty
   a_no_pull_on_output: assert property (p_no_pull_on_output) else $error("pull-up on driven pin");
   property p_drive_when_enabled;
      ((a_pin_out & ~a_pin_oe) | (b_pin_out & ~b_pin_oe)) == 8'h00;
   endproperty
   a_drive_when_enabled: assert property (p_drive_when_enabled) else $error("value on idle pin");
   property p_sync_two_stage;
      up_cnt == 2'h3 |-> alt_func == $past(b_pin_in, 2);
   endproperty
   a_sync_two_stage: assert property (p_sync_two_stage) else $error("tap not two cycles late");
   property p_write_answer;
      s_wr_taken |-> ##2 s_axi_bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer) else $error("no write response");
   property p_read_answer;
      s_rd_taken |=> s_axi_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("no read data");
   property p_read_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("read data dropped");
   property p_rdata_upper_zero;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_rdata_upper_zero: assert property (p_rdata_upper_zero) else $error("upper read bits set");
   property p_pins_after_write;
      !$stable({a_pin_oe, b_pin_oe, a_pull_up_en, b_pull_up_en}) |-> $past(s_axi_bvalid);
   endproperty
   a_pins_after_write: assert property (p_pins_after_write) else $error("pins changed unasked");
endmodule : dual_gpio_port_assertions

bind dual_gpio_port dual_gpio_port_assertions chk_u (.clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .a_pin_out(a_pin_out), .a_pin_oe(a_pin_oe), .a_pull_up_en(a_pull_up_en), .b_pin_out(b_pin_out),
   .b_pin_oe(b_pin_oe), .b_pull_up_en(b_pull_up_en), .b_pin_in(b_pin_in), .alt_func(alt_func));

// ==== dv/dual_gpio_port_tb.sv ====
/* bench for the dual port block: AXI4-Lite master tasks, read and write answer queues
   checked by a monitor, a board model on each port.
   assumes the package map, one 250 MHz clock, async low reset. */
`timescale 1ns/1ps
module dual_gpio_port_tb import gpio_pkg::*;;
   logic clk = 1'b0, clk_run = 1'b1, rst_n = 1'b0; // clock, clock gate, reset
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // byte addresses
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0; // write handshakes
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0; // read handshakes
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata; // data
   logic [3:0] s_axi_wstrb = 4'hf; // byte strobes
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid; // slave side
   logic [1:0] s_axi_bresp, s_axi_rresp; // responses
   logic [7:0] a_pin_in, a_pin_out, a_pin_oe, a_pull_up_en, b_pin_in, b_pin_out, b_pin_oe, b_pull_up_en;
   logic [7:0] a_ext_val = 8'h00, a_ext_en = 8'h00, b_ext_val = 8'h00, b_ext_en = 8'h00; // board drive
   alt_func_t alt_func; // synced port b taps
   logic [7:0] mdl [4] = '{default: 8'h00}; // expected a latch, a dir, b latch, b dir
   // register order matches the bit-command targets
   logic [7:0] ridx [4] = '{IDX_A_OUTPUT_LATCH, IDX_A_DIRECTION, IDX_B_OUTPUT_LATCH, IDX_B_DIRECTION};
   logic [33:0] rq [$]; // expected {rresp, rdata}
   logic [1:0] bq [$]; // expected bresp
   int error_cnt = 0, cmp_count = 0;
   integer seed = 73823; // fixed seed
   logic [2:0] k; // bit number
   logic [1:0] t; // bit target

   initial forever #2 if (clk_run) clk = ~clk;

   dual_gpio_port #(.ADDR_W(8)) dut_u (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .a_pin_in, .a_pin_out, .a_pin_oe, .a_pull_up_en, .b_pin_in, .b_pin_out, .b_pin_oe,
      .b_pull_up_en, .alt_func);
   pin_board_model brd_a_u (.clk, .pin_out(a_pin_out), .pin_oe(a_pin_oe), .pull_up_en(a_pull_up_en),
      .ext_val(a_ext_val), .ext_en(a_ext_en), .level(a_pin_in));
   pin_board_model brd_b_u (.clk, .pin_out(b_pin_out), .pin_oe(b_pin_oe), .pull_up_en(b_pull_up_en),
      .ext_val(b_ext_val), .ext_en(b_ext_en), .level(b_pin_in));

   function automatic logic [7:0] ba(input logic [7:0] idx);
      return {idx[5:0], 2'b00};
   endfunction : ba

   task automatic chk(input logic [33:0] got, input logic [33:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic close_out;
      if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : close_out

   // write: both halves offered together, bready raised once bvalid is seen
   task automatic wr(input logic [7:0] adr, input logic [31:0] d, input logic [3:0] st, input logic [1:0] er);
      bq.push_back(er);
      s_axi_awaddr <= adr;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      s_axi_bready <= 1'b0;
   endtask : wr

   // read: rready raised late so the data must stand
   task automatic rd(input logic [7:0] adr, input logic [31:0] d, input logic [1:0] er);
      rq.push_back({er, d});
      s_axi_araddr <= adr;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic put_all;
      foreach (mdl[i]) wr(ba(ridx[i]), 32'(mdl[i]), 4'hf, RESP_OKAY);
   endtask : put_all

   task automatic get_all;
      foreach (mdl[i]) rd(ba(ridx[i]), 32'(mdl[i]), RESP_OKAY);
   endtask : get_all

   // expected pin outputs from the model; serial overrides per control
   task automatic pins(input logic [2:0] ctl);
      logic [7:0] frc;
      logic [7:0] oe;
      frc = !ctl[0] ? 8'h00 : ctl[1] ? 8'h40 : 8'hb0;
      oe = mdl[3] & ~frc;
      chk(34'({a_pin_oe, a_pin_out, a_pull_up_en}), 34'({mdl[1], mdl[0] & mdl[1], mdl[0] & ~mdl[1]}));
      chk(34'({b_pin_oe, b_pin_out, b_pull_up_en}), 34'({oe, mdl[2] & oe, mdl[2] & ~oe}));
   endtask : pins

   // monitor: every answer is matched to the oldest note
   always @(posedge clk) begin
      if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
      if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), 34'(bq.pop_front()));
   end

   // watchdog: run needs under a thousand cycles, limit is 25000
   initial begin
      #100000;
      error_cnt++;
      close_out();
   end

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      pins(3'h0);
      get_all();
      for (int i = 0; i < 8; i++) begin
         foreach (mdl[j]) mdl[j] = 8'($random(seed));
         a_ext_val <= 8'($random(seed));
         b_ext_val <= 8'($random(seed));
         a_ext_en <= ~mdl[1];
         b_ext_en <= ~mdl[3];
         put_all();
         pins(3'h0);
         get_all();
         rd(ba(IDX_A_PIN_LEVELS), 32'(mdl[0] & mdl[1] | a_ext_val & ~mdl[1]), RESP_OKAY);
         rd(ba(IDX_B_PIN_LEVELS), 32'(mdl[2] & mdl[3] | b_ext_val & ~mdl[3]), RESP_OKAY);
         chk(34'(alt_func), 34'(mdl[2] & mdl[3] | b_ext_val & ~mdl[3]));
      end
      wr(ba(IDX_A_PIN_LEVELS), 32'hff, 4'hf, RESP_OKAY);
      wr(ba(IDX_B_PIN_LEVELS), 32'hff, 4'hf, RESP_OKAY);
      wr(ba(ridx[0]), 32'h0, 4'he, RESP_OKAY);
      wr(8'h70, 32'hff, 4'hf, RESP_SLVERR);
      rd(8'h70, 32'h0, RESP_SLVERR);
      rd(ba(IDX_BIT_OP), 32'h0, RESP_SLVERR);
      get_all();
      for (int i = 0; i < 16; i++) begin
         t = 2'(i);
         k = 3'($random(seed));
         wr(ba(IDX_BIT_OP), 32'({t, (i < 8), k}), 4'hf, RESP_OKAY);
         mdl[t][k] = (i < 8);
         pins(3'h0);
      end
      get_all();
      // software programs serial-pin direction itself
      mdl[3] = 8'hff;
      put_all();
      for (int c = 1; c < 4; c += 2) begin
         wr(ba(IDX_CONTROL), 32'(c), 4'hf, RESP_OKAY);
         rd(ba(IDX_CONTROL), 32'(c), RESP_OKAY);
         pins(3'(c));
      end
      // port a kept quiet as input while gated
      mdl[1] = 8'h00;
      mdl[3] = 8'h00;
      a_ext_en <= 8'hff;
      a_ext_val <= 8'hff;
      b_ext_en <= 8'hff;
      wr(ba(IDX_CONTROL), 32'h4, 4'hf, RESP_OKAY);
      put_all();
      rd(ba(IDX_A_PIN_LEVELS), 32'h0, RESP_OKAY);
      wr(ba(IDX_CONTROL), 32'h0, 4'hf, RESP_OKAY);
      rd(ba(IDX_B_PIN_LEVELS), 32'(b_ext_val), RESP_OKAY);
      rd(ba(IDX_A_PIN_LEVELS), 32'hff, RESP_OKAY);
      mdl = '{default: 8'hff};
      put_all();
      @(negedge clk);
      clk_run = 1'b0;
      #1 rst_n = 1'b0;
      mdl = '{default: 8'h00};
      #1 pins(3'h0);
      clk_run = 1'b1;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      get_all();
      close_out();
   end
endmodule : dual_gpio_port_tb

// ==== dv/pin_board_model.sv ====
/* board circuitry on one 8-bit port: resolves each pin's level.
   where the bench drives a pin the block drives, the block's value wins. */
`timescale 1ns/1ps
module pin_board_model (
   input wire logic clk, // paces the floating pattern
   input wire logic [7:0] pin_out, // block drive values
   input wire logic [7:0] pin_oe, // block drive enables
   input wire logic [7:0] pull_up_en, // block pull-ups
   input wire logic [7:0] ext_val, // board drive values
   input wire logic [7:0] ext_en, // board drive enables
   output logic [7:0] level // resolved pin levels
);
   logic [7:0] float_reg = 8'h5a; // undriven pins wander, never a steady guess
   // floating pattern flips every cycle
   always_ff @(posedge clk) begin
      float_reg <= ~float_reg;
   end
   // block drive wins, then board, then pull-up, else floating
   assign level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) | (~pin_oe & ~ext_en & pull_up_en)
      | (~pin_oe & ~ext_en & ~pull_up_en & float_reg);
endmodule : pin_board_model

// ==== logic/dual_gpio_port.sv ====
/*
 * two 8-bit general-purpose ports behind an AXI4-Lite slave, with single-bit
 * set/clear commands, serial-interface direction overrides, port a power-down input
 * gating and port b alternate-function taps. assumes one clock, inputs
 * synchronous to it, and a pad ring that turns out/oe/pull into pin levels.
 */
`timescale 1ns/1ps
module dual_gpio_port
   import gpio_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic clk, // system clock, 250 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic [PORT_W-1:0] a_pin_in, // port a pin levels
   output logic [PORT_W-1:0] a_pin_out, // port a drive values
   output logic [PORT_W-1:0] a_pin_oe, // port a drive enables
   output logic [PORT_W-1:0] a_pull_up_en, // port a pull-ups
   input wire logic [PORT_W-1:0] b_pin_in, // port b pin levels
   output logic [PORT_W-1:0] b_pin_out, // port b drive values
   output logic [PORT_W-1:0] b_pin_oe, // port b drive enables
   output logic [PORT_W-1:0] b_pull_up_en, // port b pull-ups
   output alt_func_t alt_func // port b levels to peripherals
);
   // port registers
   logic [PORT_W-1:0] a_latch_reg; // port_a_output_latch
   logic [PORT_W-1:0] a_dir_reg; // port_a_direction
   logic [PORT_W-1:0] b_latch_reg; // port_b_output_latch
   logic [PORT_W-1:0] b_dir_reg; // port_b_direction
   control_t ctrl_reg; // serial mode and power-down

   // synchronised pin levels from the slices
   logic [PORT_W-1:0] a_level; // port_a_pin_levels
   logic [PORT_W-1:0] b_level; // port_b_pin_levels
   logic [PORT_W-1:0] b_force; // port b forced-input mask

   // write channel state
   logic aw_held_reg; // address captured
   logic w_held_reg; // data captured
   logic [ADDR_W-1:0] awaddr_reg; // captured address
   logic [31:0] wdata_reg; // captured data
   logic wstrb0_reg; // low byte strobe
   logic bvalid_reg; // response pending
   logic [1:0] bresp_reg; // response code
   logic do_write; // both halves present
   reg_sel_t wsel; // decoded write target
   logic wr_bitop; // write hits bit command
   logic wr_ok; // write lands in a mapped slot

   // read channel state
   logic rvalid_reg; // read data pending
   logic [31:0] rdata_reg; // read data
   logic [1:0] rresp_reg; // read response
   reg_sel_t rsel; // decoded read target
   logic [PORT_W-1:0] rbyte; // selected read value
   logic rd_ok; // read hits a mapped slot

   // bit command decode
   logic [2:0] bit_num; // bit to modify
   logic bit_val; // new value of that bit
   bit_target_t bit_tgt; // register to modify

   // byte address of a register index
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = ADDR_W'({idx, 2'b00});
   endfunction : byte_addr

   // address decode shared by read and write
   // the bit command slot is write-only, so it is decoded apart
   function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
      if (addr == byte_addr(IDX_A_OUTPUT_LATCH)) decode = SEL_A_LATCH;
      else if (addr == byte_addr(IDX_A_DIRECTION)) decode = SEL_A_DIR;
      else if (addr == byte_addr(IDX_A_PIN_LEVELS)) decode = SEL_A_PINS;
      else if (addr == byte_addr(IDX_B_OUTPUT_LATCH)) decode = SEL_B_LATCH;
      else if (addr == byte_addr(IDX_B_DIRECTION)) decode = SEL_B_DIR;
      else if (addr == byte_addr(IDX_B_PIN_LEVELS)) decode = SEL_B_PINS;
      else if (addr == byte_addr(IDX_CONTROL)) decode = SEL_CTRL;
      else decode = SEL_NONE;
   endfunction : decode

   // replace one bit, keep the rest
   function automatic logic [PORT_W-1:0] put_bit(input logic [PORT_W-1:0] cur,
                                                 input logic [2:0] num, input logic val);
      logic [PORT_W-1:0] res;
      res = cur;
      res[num] = val;
      put_bit = res;
   endfunction : put_bit

   // write side decode
   assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign wsel = decode(awaddr_reg);
   assign wr_bitop = (awaddr_reg == byte_addr(IDX_BIT_OP));
   assign wr_ok = (wsel != SEL_NONE) | wr_bitop;
   assign bit_num = wdata_reg[BITOP_NUM_LSB +: 3];
   assign bit_val = wdata_reg[BITOP_VAL_POS];
   assign bit_tgt = bit_target_t'(wdata_reg[BITOP_TGT_LSB +: 2]);

   // channels accept only while no response is waiting
   assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // write address and data captured in either order
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= '0;
         wdata_reg <= '0;
         wstrb0_reg <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb0_reg <= s_axi_wstrb[0];
         end else if (do_write) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   // write response, one per completed write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         // unmapped slots answer with an error and change nothing
         bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // port registers: whole-byte writes and single-bit commands
   // writes to the pin slots fall through and change nothing
   // a cleared low strobe leaves every register as it was
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_latch_reg <= RST_LATCH;
         a_dir_reg <= RST_DIRECTION;
         b_latch_reg <= RST_LATCH;
         b_dir_reg <= RST_DIRECTION;
      end else if (do_write && wstrb0_reg) begin
         if (wr_bitop) begin
            case (bit_tgt)
               TGT_A_LATCH: a_latch_reg <= put_bit(a_latch_reg, bit_num, bit_val);
               TGT_A_DIR: a_dir_reg <= put_bit(a_dir_reg, bit_num, bit_val);
               TGT_B_LATCH: b_latch_reg <= put_bit(b_latch_reg, bit_num, bit_val);
               TGT_B_DIR: b_dir_reg <= put_bit(b_dir_reg, bit_num, bit_val);
               default: a_latch_reg <= a_latch_reg;
            endcase
         end else begin
            case (wsel)
               SEL_A_LATCH: a_latch_reg <= wdata_reg[PORT_W-1:0];
               SEL_A_DIR: a_dir_reg <= wdata_reg[PORT_W-1:0];
               SEL_B_LATCH: b_latch_reg <= wdata_reg[PORT_W-1:0];
               SEL_B_DIR: b_dir_reg <= wdata_reg[PORT_W-1:0];
               default: a_latch_reg <= a_latch_reg;
            endcase
         end
      end
   end

   // control register: serial mode and power-down sleep
   // in a full chip these come from the serial block and sleep logic
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= RST_CONTROL;
      end else if (do_write && wstrb0_reg && wsel == SEL_CTRL) begin
         ctrl_reg.spi_enable <= wdata_reg[CTL_SPI_EN_POS];
         ctrl_reg.spi_master <= wdata_reg[CTL_SPI_MASTER_POS];
         ctrl_reg.power_down <= wdata_reg[CTL_POWER_DOWN_POS];
      end
   end

   // read value select
   assign rsel = decode(s_axi_araddr);
   assign rd_ok = (rsel != SEL_NONE);

   always_comb begin
      case (rsel)
         SEL_A_LATCH: rbyte = a_latch_reg;
         SEL_A_DIR: rbyte = a_dir_reg;
         SEL_A_PINS: rbyte = a_level;
         SEL_B_LATCH: rbyte = b_latch_reg;
         SEL_B_DIR: rbyte = b_dir_reg;
         SEL_B_PINS: rbyte = b_level;
         SEL_CTRL: rbyte = {{(PORT_W-3){1'b0}}, ctrl_reg};
         default: rbyte = '0;
      endcase
   end

   // read channel: answer one cycle after the address is taken
   // upper bits read as zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= '0;
         rresp_reg <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rdata_reg <= {24'h000000, rbyte};
         rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // forced inputs on port b while the serial block owns its pins
   // the latch still drives the pull-ups of forced pins
   always_comb begin
      b_force = '0;
      if (ctrl_reg.spi_enable && !ctrl_reg.spi_master) begin
         b_force[B_SCK_POS] = 1'b1;
         b_force[B_MOSI_POS] = 1'b1;
         b_force[B_SS_POS] = 1'b1;
      end else if (ctrl_reg.spi_enable) begin
         b_force[B_MISO_POS] = 1'b1;
      end
   end

   // identical per-pin logic
   // port a: inputs gated off during power-down sleep
   port_pin_slice #(
      .W(PORT_W)
   ) u_port_a (
      .clk(clk),
      .rst_n(rst_n),
      .latch_in(a_latch_reg),
      .dir_in(a_dir_reg),
      .force_in({PORT_W{1'b0}}),
      .gate_in(ctrl_reg.power_down),
      .pad_in(a_pin_in),
      .pad_out(a_pin_out),
      .pad_oe(a_pin_oe),
      .pull_up_en(a_pull_up_en),
      .level(a_level)
   );

   // port b: serial overrides applied, inputs never gated
   port_pin_slice #(
      .W(PORT_W)
   ) u_port_b (
      .clk(clk),
      .rst_n(rst_n),
      .latch_in(b_latch_reg),
      .dir_in(b_dir_reg),
      .force_in(b_force),
      .gate_in(1'b0),
      .pad_in(b_pin_in),
      .pad_out(b_pin_out),
      .pad_oe(b_pin_oe),
      .pull_up_en(b_pull_up_en),
      .level(b_level)
   );

   // port b alternate-function taps
   // levels come from the synchroniser, so peripherals see clean edges
   assign alt_func = alt_func_t'(b_level);
endmodule : dual_gpio_port

// ==== logic/gpio_pkg.sv ====
/*
 * shared constants and types for the dual 8-bit general-purpose port block:
 * register indices and byte addresses, reset values, field positions and the
 * carrier structs. assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */
package gpio_pkg;
   // port width, one bit per pin in every port register
   localparam int PORT_W = 8;
   // register indices as printed; byte address is four times the index
   localparam logic [7:0] IDX_B_PIN_LEVELS = 8'h16;
   localparam logic [7:0] IDX_B_DIRECTION = 8'h17;
   localparam logic [7:0] IDX_B_OUTPUT_LATCH = 8'h18;
   localparam logic [7:0] IDX_A_PIN_LEVELS = 8'h19;
   localparam logic [7:0] IDX_A_DIRECTION = 8'h1a;
   localparam logic [7:0] IDX_A_OUTPUT_LATCH = 8'h1b;
   // extra registers: bit set/clear command and block control
   localparam logic [7:0] IDX_BIT_OP = 8'h20;
   localparam logic [7:0] IDX_CONTROL = 8'h21;
   // reset values of the read/write registers
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_DIRECTION = 8'h00;
   localparam logic [2:0] RST_CONTROL = 3'h0;
   // bit command fields: [2:0] bit number, [3] new value, [5:4] target
   localparam int BITOP_NUM_LSB = 0;
   localparam int BITOP_VAL_POS = 3;
   localparam int BITOP_TGT_LSB = 4;
   // control fields
   localparam int CTL_SPI_EN_POS = 0;
   localparam int CTL_SPI_MASTER_POS = 1;
   localparam int CTL_POWER_DOWN_POS = 2;
   // port b pin positions of the serial interface
   localparam int B_SS_POS = 4;
   localparam int B_MOSI_POS = 5;
   localparam int B_MISO_POS = 6;
   localparam int B_SCK_POS = 7;
   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // target of a single-bit command
   typedef enum logic [1:0] {
      TGT_A_LATCH = 2'b00,
      TGT_A_DIR = 2'b01,
      TGT_B_LATCH = 2'b10,
      TGT_B_DIR = 2'b11
   } bit_target_t;

   // decoded register selection
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_A_LATCH = 3'b001,
      SEL_A_DIR = 3'b010,
      SEL_A_PINS = 3'b011,
      SEL_B_LATCH = 3'b100,
      SEL_B_DIR = 3'b101,
      SEL_B_PINS = 3'b110,
      SEL_CTRL = 3'b111
   } reg_sel_t;

   // block control bits
   typedef struct packed {
      logic power_down;
      logic spi_master;
      logic spi_enable;
   } control_t;

   // synchronised port b levels handed to the alternate-function users
   typedef struct packed {
      logic spi_sck;
      logic spi_miso;
      logic spi_mosi;
      logic spi_ss;
      logic comparator_negative_input;
      logic comparator_positive_input;
      logic timer_one_count_input;
      logic timer_zero_count_input;
   } alt_func_t;
endpackage : gpio_pkg

// ==== logic/port_pin_slice.sv ====
/*
 * pin logic of one 8-bit port: drive, enable and pull-up outputs and the
 * two-stage input synchroniser. assumes latch and direction come from the
 * register file on the same clock; the pad ring resolves pin level from oe.
 */
`timescale 1ns/1ps
module port_pin_slice #(
   parameter int W = 8
) (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic [W-1:0] latch_in, // data latch bits
   input wire logic [W-1:0] dir_in, // direction bits, 1 = output
   input wire logic [W-1:0] force_in, // 1 forces the pin to input
   input wire logic gate_in, // 1 disconnects the input buffers
   input wire logic [W-1:0] pad_in, // pin level from the pad
   output logic [W-1:0] pad_out, // drive value
   output logic [W-1:0] pad_oe, // drive enable, high while driving
   output logic [W-1:0] pull_up_en, // pull-up enable
   output logic [W-1:0] level // synchronised pin level
);
   logic [W-1:0] eff_dir; // direction after forced inputs
   logic [W-1:0] gated_in; // pad level after input gating
   logic [W-1:0] sync1_reg; // first synchroniser stage
   logic [W-1:0] sync2_reg; // second synchroniser stage

   // forced inputs win over the direction bits
   assign eff_dir = dir_in & ~force_in;
   assign gated_in = pad_in & ~{W{gate_in}};

   // push-pull, pull-up
   // reset clears all three so pins float without a clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pad_oe <= '0;
         pad_out <= '0;
         pull_up_en <= '0;
      end else begin
         pad_oe <= eff_dir;
         pad_out <= latch_in & eff_dir;
         pull_up_en <= latch_in & ~eff_dir;
      end
   end

   // two-flop synchroniser
   // only the second stage is read anywhere
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= gated_in;
         sync2_reg <= sync1_reg;
      end
   end

   assign level = sync2_reg;
endmodule : port_pin_slice
